// ===== src/tmr_defines.svh
// Constants of the 8-bit event-count and pulse-output timer.
// Assumes the including file uses them as widths, indices and fields.
//
// Overview of operation
// R01: Counter increments once per timer-pin event
// R02: Event source is raw or synchronized pin
// R03: Raw source counts on pin falling edge
// R04: Synchronized source uses falling system-clock synchronizer
// R05: Synchronized counting keeps counter reads correct
// R06: Raw counting reads may catch wrong value
// R07: Software clears counter first; zero compare synchronized
// R08: Only raw pin counting wakes from stop
// R09: Stop timer before rewriting compare in raw mode
// R10: Match sets flag, clears counter, counting resumes
// R11: Compare write initializes counter to zero; code does so only while stopped
// R12: Mode bits 2-0 select count clock source
// R13: Mode bit 3 stops or runs counter
// R14: Mode bits 4,5 zero select normal operation
// R15: Prescaler select: divider bits 2-1, base bit 0
// R16: Interrupt control: level bits 7-6, enable bit 1
// R17: Software makes timer pin an input for events
// R18: Pulse mode: pin output inverts on each match
// R19: Pulse period is twice the compare interval
// R20: Compare write while stopped drives output low
// R21: Software enables pin special function and output
// R22: Compare write while running keeps counter value
// R23: Never change enable and source together
// R24: Eight-bit counter and compare, counter wraps
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ****************************************************************
// Register word indices (byte address is four times the index)
// ****************************************************************
`define TMR_IDX_COMPARE 14'h3F52
`define TMR_IDX_COUNT   14'h3F53
`define TMR_IDX_MODE    14'h3F54
`define TMR_IDX_STATUS  14'h3F55
`define TMR_IDX_PSEL    14'h3F56
`define TMR_IDX_PINCTL  14'h3F57
`define TMR_IDX_ICR     14'h3FE7

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define TMR_MODE_SRC_HI  2
`define TMR_MODE_SRC_LO  0
`define TMR_MODE_EN      3
`define TMR_MODE_PWM     4
`define TMR_MODE_CASC    5
`define TMR_SRC_PIN_RAW  3'h6
`define TMR_SRC_PIN_SYNC 3'h7
`define TMR_SRC_PRESC    2'h1
`define TMR_PSEL_DIV_HI  2
`define TMR_PSEL_DIV_LO  1
`define TMR_PSEL_BASE    0
`define TMR_ICR_LV_HI    7
`define TMR_ICR_LV_LO    6
`define TMR_ICR_IE       1
`define TMR_STAT_FLAG    0
`define TMR_STAT_PIN     1
`define TMR_PIN_DIR      0
`define TMR_PIN_SF       1

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define TMR_RST8   8'h00
`define TMR_RST32  32'h0000_0000
`define TMR_ONE8   8'h01

`endif

// ===== src/tmr_event_timer.sv
// 8-bit timer with event counting and pulse output, Avalon-MM slave.
// Assumes a 250 MHz clk_in, an external prescaler giving one-cycle
// ticks, and the port logic combining the pin enable with the pad.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "tmr_defines.svh"
module tmr_event_timer (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Avalon-MM slave, byte address, 32-bit data
  input  wire logic [15:0] avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Timer pin, split into its three signals
  input  wire logic        timer_io_pin_in,
  output logic             timer_io_pin_out,
  output logic             timer_io_pin_oe_out,
  // Prescaler interface
  input  wire logic        prescale_tick_in,
  output logic      [1:0]  prescaler_div_out,
  output logic             prescaler_base_out,
  // Interrupt controller interface
  output logic             irq_flag_out,
  output logic             int_enable_out,
  output logic      [1:0]  int_level_out,
  output logic             match_pulse_out,
  output logic             wake_req_out
);

  // ****************************************************************
  // Pin input paths
  // ****************************************************************
  logic raw_level;
  logic raw_fall;
  logic sync_level;
  logic sync_fall;

  // Raw path: plain two-flop capture, rising clock edge
  tmr_pin_sync #(
    .FALL (1'b0)
  ) u_raw_sync (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .pin_in    (timer_io_pin_in),
    .level_out (raw_level)
  );

  // Synchronised path: stages on the falling system clock edge [R04]
  tmr_pin_sync #(
    .FALL (1'b1)
  ) u_fall_sync (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .pin_in    (timer_io_pin_in),
    .level_out (sync_level)
  );

  // Falling edge of the pin on the raw path [R03]
  tmr_fall_det u_raw_edge (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .level_in (raw_level),
    .fall_out (raw_fall)
  );

  // Falling edge of the synchroniser output [R04]
  tmr_fall_det u_sync_edge (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .level_in (sync_level),
    .fall_out (sync_fall)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  tmr_pkg::tmr_state_s s_q;
  tmr_pkg::tmr_state_s s_d;

  tmr_pkg::tmr_src_e   src;
  logic [2:0]          src_code;
  logic                run;
  logic                tick;
  logic                req;
  logic                wr_go;
  logic                hit;
  logic                set_flag;
  logic [13:0]         idx;
  logic [7:0]          wbyte;

  // ****************************************************************
  // Source decode and count enable
  // ****************************************************************

  // Mode field picks the count clock [R12] [R02]
  always_comb begin
    src_code = s_q.mode[`TMR_MODE_SRC_HI:`TMR_MODE_SRC_LO];
    if (src_code == `TMR_SRC_PIN_RAW) begin
      src = tmr_pkg::SRC_PIN_RAW;
    end else if (src_code == `TMR_SRC_PIN_SYNC) begin
      src = tmr_pkg::SRC_PIN_SYNC;
    end else if (src_code[1:0] == `TMR_SRC_PRESC) begin
      src = tmr_pkg::SRC_PRESC;
    end else begin
      src = tmr_pkg::SRC_NONE;
    end
  end

  // One count-clock event per pin falling edge or prescaler tick [R01]
  always_comb begin
    case (src)
      tmr_pkg::SRC_PRESC: begin
        tick = prescale_tick_in;
      end
      tmr_pkg::SRC_PIN_RAW: begin
        tick = raw_fall;  // [R03]
      end
      tmr_pkg::SRC_PIN_SYNC: begin
        tick = sync_fall;  // [R05]
      end
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  // Count only when enabled and in normal mode [R13] [R14]
  assign run = s_q.mode[`TMR_MODE_EN] &
               ~s_q.mode[`TMR_MODE_PWM] &
               ~s_q.mode[`TMR_MODE_CASC];

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  // Every access waits exactly one cycle; simple and uniform timing
  assign req   = avs_read_in | avs_write_in;
  assign idx   = avs_address_in[15:2];
  assign wbyte = avs_writedata_in[7:0];
  assign wr_go = avs_write_in & s_q.ack & avs_byteenable_in[0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d       = s_q;
    s_d.match = 1'b0;
    set_flag  = 1'b0;
    hit       = 1'b0;

    // Handshake: raise ack for one cycle after a fresh request
    s_d.ack = req & ~s_q.ack;

    // Counter advance, match and wrap [R10] [R24]
    if (run && tick) begin
      if (s_q.cnt == s_q.cmp) begin
        s_d.cnt   = `TMR_RST8;
        set_flag  = 1'b1;
        s_d.match = 1'b1;
        s_d.pin   = ~s_q.pin;  // [R18] [R19]
      end else begin
        s_d.cnt = s_q.cnt + `TMR_ONE8;  // wraps past 8'hFF
      end
    end

    // Register writes take effect at the edge ending the ack cycle
    if (wr_go) begin
      case (idx)
        `TMR_IDX_COMPARE: begin
          s_d.cmp = wbyte;
          // Running timer keeps its count [R22]
          if (!s_q.mode[`TMR_MODE_EN]) begin
            s_d.cnt = `TMR_RST8;  // [R11]
            s_d.pin = 1'b0;       // [R20]
          end
        end
        `TMR_IDX_MODE: begin
          s_d.mode = wbyte;
        end
        `TMR_IDX_PSEL: begin
          s_d.psel = wbyte;  // [R15]
        end
        `TMR_IDX_ICR: begin
          s_d.icr = wbyte;  // [R16]
        end
        `TMR_IDX_PINCTL: begin
          s_d.pinctl = wbyte;
        end
        `TMR_IDX_STATUS: begin
          // Write one clears the request flag
          if (wbyte[`TMR_STAT_FLAG]) begin
            s_d.flag = 1'b0;
          end
        end
        default: begin
          hit = 1'b0;  // unmapped: write ignored
        end
      endcase
    end

    // A match in the clearing cycle still sets the flag [R10]
    if (set_flag) begin
      s_d.flag = 1'b1;
    end

    // Read data captured on the first cycle, shown at the ack edge
    if (avs_read_in && !s_q.ack) begin
      hit = 1'b1;
      case (idx)
        `TMR_IDX_COMPARE: begin
          s_d.rdata = {24'h000000, s_q.cmp};
        end
        `TMR_IDX_COUNT: begin
          // Raw-pin counting may be caught mid-step by software [R06]
          s_d.rdata = {24'h000000, s_q.cnt};
        end
        `TMR_IDX_MODE: begin
          s_d.rdata = {24'h000000, s_q.mode};
        end
        `TMR_IDX_STATUS: begin
          s_d.rdata = `TMR_RST32;
          s_d.rdata[`TMR_STAT_FLAG] = s_q.flag;
          s_d.rdata[`TMR_STAT_PIN]  = s_q.pin;
        end
        `TMR_IDX_PSEL: begin
          s_d.rdata = {24'h000000, s_q.psel};
        end
        `TMR_IDX_PINCTL: begin
          s_d.rdata = {24'h000000, s_q.pinctl};
        end
        `TMR_IDX_ICR: begin
          s_d.rdata = {24'h000000, s_q.icr};
        end
        default: begin
          s_d.rdata = `TMR_RST32;  // unmapped reads as zero
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Everything clears to zero: stopped, no source, pin low
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Waitrequest drops in the second cycle of each request
  assign avs_waitrequest_out = req & ~s_q.ack;
  assign avs_readdata_out    = s_q.rdata;

  // Pin drives only when set to output and special function
  assign timer_io_pin_out    = s_q.pin;
  assign timer_io_pin_oe_out = s_q.pinctl[`TMR_PIN_DIR] &
                               s_q.pinctl[`TMR_PIN_SF];

  // Prescaler choice goes to the shared prescaler [R15]
  assign prescaler_div_out  =
    s_q.psel[`TMR_PSEL_DIV_HI:`TMR_PSEL_DIV_LO];
  assign prescaler_base_out = s_q.psel[`TMR_PSEL_BASE];

  // Interrupt request and its control fields [R16]
  assign irq_flag_out    = s_q.flag;
  assign int_enable_out  = s_q.icr[`TMR_ICR_IE];
  assign int_level_out   = s_q.icr[`TMR_ICR_LV_HI:`TMR_ICR_LV_LO];
  assign match_pulse_out = s_q.match;

  // Only raw pin matches may wake the chip from stop [R08]
  assign wake_req_out = s_q.match &
                        (s_q.mode[`TMR_MODE_SRC_HI:`TMR_MODE_SRC_LO]
                         == `TMR_SRC_PIN_RAW);

endmodule

// ===== src/tmr_fall_det.sv
// Falling-edge detector on a synchronised level.
// Assumes the level is already in the clk_in domain.
`timescale 1ns/1ns
module tmr_fall_det (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic level_in,
  output logic      fall_out
);

  logic prev_q;
  logic prev_d;

  // Remember last level; pin idles high so reset to one
  always_comb begin
    prev_d = level_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= prev_d;
    end
  end

  // One-cycle pulse on a high-to-low step
  assign fall_out = prev_q & ~level_in;

endmodule

// ===== src/tmr_pin_sync.sv
// Two-stage synchroniser for the timer pin.
// Assumes an asynchronous pin; FALL selects the clock edge used.
`timescale 1ns/1ns
module tmr_pin_sync #(
  parameter bit FALL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic pin_in,
  output logic      level_out
);

  tmr_pkg::tmr_sync_s s_q;
  tmr_pkg::tmr_sync_s s_d;

  // Shift the pin through; only the second stage is read
  always_comb begin
    s_d.meta = pin_in;
    s_d.sync = s_q.meta;
  end

  // ****************************************************************
  // Stage registers on the chosen edge
  // ****************************************************************
  generate
    if (FALL) begin : g_fall
      always_ff @(negedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          s_q <= '1;
        end else begin
          s_q <= s_d;
        end
      end
    end else begin : g_rise
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          s_q <= '1;
        end else begin
          s_q <= s_d;
        end
      end
    end
  endgenerate

  assign level_out = s_q.sync;

endmodule

// ===== src/tmr_pkg.sv
// Types shared by the timer modules.
// Assumes tmr_defines.svh supplies all numbers.
package tmr_pkg;

  // Count clock source after decoding the mode field
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_PRESC,
    SRC_PIN_RAW,
    SRC_PIN_SYNC
  } tmr_src_e;

  // Synchroniser stages
  typedef struct packed {
    logic meta;
    logic sync;
  } tmr_sync_s;

  // Whole register state of the timer
  typedef struct packed {
    logic [7:0]  cmp;
    logic [7:0]  mode;
    logic [7:0]  psel;
    logic [7:0]  icr;
    logic [7:0]  pinctl;
    logic [7:0]  cnt;
    logic        flag;
    logic        pin;
    logic        ack;
    logic        match;
    logic [31:0] rdata;
  } tmr_state_s;

endpackage

// ===== tb/testbench.sv
// Self-checking bench for the event-count and pulse-output timer.
// Assumes the design sources, the checker and the event source model.
`timescale 1ns/1ns
module testbench;
  localparam logic [15:0] A_CMP  = 16'hFD48;
  localparam logic [15:0] A_CNT  = 16'hFD4C;
  localparam logic [15:0] A_MODE = 16'hFD50;
  localparam logic [15:0] A_STAT = 16'hFD54;
  localparam logic [15:0] A_PSEL = 16'hFD58;
  localparam logic [15:0] A_PIN  = 16'hFD5C;
  localparam logic [15:0] A_ICR  = 16'hFF9C;
  logic        clk_in = 1'b0, rst_b_in, avs_read_in, avs_write_in;
  logic [15:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0]  avs_byteenable_in;
  logic        avs_waitrequest_out, timer_io_pin_out, timer_io_pin_oe_out;
  logic        prescale_tick_in, prescaler_base_out, irq_flag_out;
  logic        int_enable_out, match_pulse_out, wake_req_out;
  logic        src_pin, pin_w;
  logic [1:0]  prescaler_div_out, int_level_out;
  int          errors = 0, check_count = 0, per;
  logic [7:0]  m;
  logic        wake_seen = 1'b0;

  // Wake pulses last one cycle, so keep a sticky record of them
  always @(posedge clk_in) begin
    if (wake_req_out === 1'b1) wake_seen <= 1'b1;
  end

  always #2 clk_in = !clk_in;
  // Timer drives the line only while its output enable is set
  assign pin_w = timer_io_pin_oe_out ? timer_io_pin_out : src_pin;

  tmr_event_timer i_tmr_event_timer (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .timer_io_pin_in(pin_w), .timer_io_pin_out(timer_io_pin_out),
    .timer_io_pin_oe_out(timer_io_pin_oe_out),
    .prescale_tick_in(prescale_tick_in),
    .prescaler_div_out(prescaler_div_out),
    .prescaler_base_out(prescaler_base_out), .irq_flag_out(irq_flag_out),
    .int_enable_out(int_enable_out), .int_level_out(int_level_out),
    .match_pulse_out(match_pulse_out), .wake_req_out(wake_req_out));
  tmr_event_source i_tmr_event_source (.clk_in(clk_in), .pin_out(src_pin));

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_write_in     <= w;
    avs_read_in      <= !w;
    avs_writedata_in <= {24'h000000, d};
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // Events then the synchroniser latency before any read
  task automatic events(input int n, input int w);
    i_tmr_event_source.send_events(n, w);
    repeat (5) @(posedge clk_in);
  endtask
  // Cycles between two rising edges of the timer output
  task automatic pulse_period(output int p);
    int   first;
    logic prev;
    first = -1;
    p = 0;
    prev = timer_io_pin_out;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk_in);
      if (!prev && timer_io_pin_out === 1'b1) begin
        if (first < 0) first = k;
        else if (p == 0) p = k - first;
      end
      prev = timer_io_pin_out;
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    rst_b_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 16'h0000;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'hF;
    prescale_tick_in = 1'b0;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // Reset values, then field outputs and an unmapped place
    rd(A_CMP, 32'h0); rd(A_MODE, 32'h0);
    rd(A_PSEL, 32'h0); rd(A_ICR, 32'h0);
    wr(A_PSEL, 8'h07);
    rd(A_PSEL, 32'h7);
    @(negedge clk_in);
    chk({prescaler_div_out, prescaler_base_out}, 32'h7);
    wr(A_ICR, 8'hC2);
    @(negedge clk_in);
    chk({int_level_out, int_enable_out}, 32'h7);
    wr(16'h0010, 8'h5A);
    rd(16'h0010, 32'h0);
    // Raw pin counting, match, flag and status clear
    wr(A_MODE, 8'h06);
    wr(A_CMP, 8'h04);
    rd(A_CNT, 32'h0);
    wr(A_MODE, 8'h0E);
    events(4, 2);
    rd(A_CNT, 32'h4);
    events(1, 2);
    rd(A_CNT, 32'h0);
    rd(A_STAT, 32'h3);
    chk(irq_flag_out, 32'h1);
    chk(wake_seen, 32'h1);
    wr(A_STAT, 8'h01);
    rd(A_STAT, 32'h2);
    chk(irq_flag_out, 32'h0);
    // Synchronised source, running compare rewrite, stop
    wr(A_MODE, 8'h06);
    wr(A_MODE, 8'h07);
    wr(A_CMP, 8'h04);
    rd(A_STAT, 32'h0);
    wr(A_MODE, 8'h0F);
    events(3, 3);
    rd(A_CNT, 32'h3);
    wr(A_CMP, 8'h10);
    rd(A_CNT, 32'h3);
    wr(A_MODE, 8'h07);
    events(2, 2);
    rd(A_CNT, 32'h3);
    // Pwm or cascade set: no normal counting
    for (int j = 0; j < 2; j++) begin
      m = (j == 0) ? 8'h10 : 8'h20;
      wr(A_MODE, 8'h07 | m);
      wr(A_MODE, 8'h0F | m);
      events(2, 2);
      rd(A_CNT, 32'h3);
    end
    wr(A_MODE, 8'h27);
    // Pulse output from the prescaler for both source codes
    wr(A_PIN, 8'h03);
    @(negedge clk_in);
    chk(timer_io_pin_oe_out, 32'h1);
    for (int j = 0; j < 2; j++) begin
      m = (j == 0) ? 8'h01 : 8'h05;
      wr(A_MODE, m);
      wr(A_CMP, 8'h02);
      prescale_tick_in <= 1'b1;
      wr(A_MODE, 8'h08 | m);
      pulse_period(per);
      chk(per, 32'd6);
      @(posedge clk_in);
      prescale_tick_in <= 1'b0;
      wr(A_MODE, m);
    end
    complete_run();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    complete_run();
  end
endmodule

bind tmr_event_timer tmr_event_timer_asserts i_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .timer_io_pin_out(timer_io_pin_out), .irq_flag_out(irq_flag_out),
  .match_pulse_out(match_pulse_out), .wake_req_out(wake_req_out));

// ===== tb/tmr_event_source.sv
// Model of the external event source on the timer pin.
// Assumes the bench merges its level with the timer's own drive.
`timescale 1ns/1ns
module tmr_event_source (
  input  wire logic clk_in,
  output logic      pin_out
);
  // Pulled-up line idles high between events
  initial pin_out = 1'b1;

  // One falling edge per event; width sets the pace (2 = prompt)
  task automatic send_events(input int n, input int width);
    for (int i = 0; i < n; i++) begin
      pin_out <= 1'b0;
      repeat (width) @(posedge clk_in);
      pin_out <= 1'b1;
      repeat (width) @(posedge clk_in);
    end
  endtask
endmodule

// ===== tb/tmr_event_timer_asserts.sv
// Port-level assertions for the event-count and pulse-output timer.
// Assumes a bind to tmr_event_timer in the bench top file.
`timescale 1ns/1ns
module tmr_event_timer_asserts (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        timer_io_pin_out,
  input wire logic        irq_flag_out,
  input wire logic        match_pulse_out,
  input wire logic        wake_req_out
);
  // ************************************************************
  // Checks, all in the single clock domain
  // ************************************************************
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // One wait state per request
  wait_state_a: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
    else $error("waitrequest held past one cycle");
  // Read data only moves when a read is in progress
  read_hold_a: assert property (
    !avs_read_in |=> $stable(avs_readdata_out))
    else $error("read data changed without a read");
  upper_zero_a: assert property (
    avs_readdata_out[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  // A request flag only appears together with a match
  flag_match_a: assert property (
    $rose(irq_flag_out) |-> ##[0:1] match_pulse_out)
    else $error("flag rose without a match");
  flag_sticky_a: assert property (
    irq_flag_out && !avs_write_in |=> irq_flag_out)
    else $error("flag dropped without a write");
  pin_rise_a: assert property (
    $rose(timer_io_pin_out) |-> ##[0:1] match_pulse_out)
    else $error("pin rose without a match");
  // A fall comes from a match or from a compare write
  pin_fall_a: assert property (
    $fell(timer_io_pin_out) && !$past(avs_write_in)
      |-> ##[0:1] match_pulse_out)
    else $error("pin fell without cause");
  wake_match_a: assert property (
    wake_req_out |-> match_pulse_out)
    else $error("wake request without a match");
endmodule
